// file: shared/mau_pkg.sv
// package for the memory access unit: register map, decode ranges, vectors, timing
// assumes a single-clock design reached over an ahb-lite slave port
package mau_pkg;
    // ---------------------------------------------------------------
    // register offsets (byte addresses on the ahb-lite port)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_STRETCH = 8'h00;
    localparam logic [7:0] OFF_PAGE = 8'h04;
    localparam logic [7:0] OFF_PSEL = 8'h08;
    localparam logic [7:0] OFF_DPTR0 = 8'h0c;
    localparam logic [7:0] OFF_SECONDARY_DATA_POINTER = 8'h10;
    localparam logic [7:0] OFF_CMD = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_RDATA = 8'h1c;
    localparam logic [7:0] OFF_CODE = 8'h20;
    localparam logic [7:0] OFF_CLKDIV = 8'h24;
    // ---------------------------------------------------------------
    // reset values and field layout
    // ---------------------------------------------------------------
    localparam logic [2:0] STRETCH_RST = 3'h1;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [15:0] PRIMARY_DATA_POINTER_RST = 16'h0000;
    localparam logic [2:0] CLKDIV_RST = 3'h0;
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_SHIFT = 3;
    localparam int CMD_OP_LSB = 24;
    localparam int CMD_DATA_LSB = 16;
    // ---------------------------------------------------------------
    // external data decode ranges
    // ---------------------------------------------------------------
    localparam logic [15:0] GENERAL_DATA_RAM_LO = 16'h0000;
    localparam logic [15:0] GENERAL_DATA_RAM_HI = 16'h07ff;
    localparam logic [15:0] EDRAM_LO = 16'h1000;
    localparam logic [15:0] EDRAM_HI = 16'h13ff;
    localparam logic [15:0] IORAM_LO = 16'h2000;
    localparam logic [15:0] IORAM_HI = 16'h20ff;
    localparam logic [15:0] EPRAM_LO = 16'h3000;
    localparam logic [15:0] EPRAM_HI = 16'h3fff;
    localparam logic [7:0] UNMAPPED_DATA = 8'hff;
    // ---------------------------------------------------------------
    // commands (op field of the command register)
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_RD_RI = 4'h1,
        CMD_WR_RI = 4'h2,
        CMD_RD_DP = 4'h3,
        CMD_WR_DP = 4'h4,
        CMD_INC_DP = 4'h5,
        CMD_FETCH = 4'h6,
        CMD_MOVC = 4'h7,
        CMD_VECTOR = 4'h8
    } mau_cmd_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_STROBE = 2'b10,
        ST_CODE = 2'b11
    } mau_state_t;
endpackage

// file: design/mau_top.sv
// memory access unit: code fetch, external data moves, dual pointers, strobe stretch
// assumes single-cycle memories on the data and code ports, ahb-lite master drives commands
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module mau_top (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic mem_addr_valid,
    output logic mem_rd,
    output logic mem_wr,
    output logic sel_gen_ram,
    output logic sel_engine_data_ram,
    output logic sel_io_ram,
    output logic sel_engine_program_ram,
    output logic [15:0] code_addr,
    output logic code_rd,
    input wire logic [7:0] code_rdata,
    output logic cpu_clk_en
);
    // ---------------------------------------------------------------
    // ahb-lite slave
    // ---------------------------------------------------------------
    logic ap_q, ap_d;
    logic wr_q, wr_d;
    logic [7:0] a_q, a_d;
    logic busy;
    always_comb begin
        ap_d = ap_q;
        wr_d = wr_q;
        a_d = a_q;
        if (hready) begin
            ap_d = hsel && htrans[1];
            wr_d = hwrite;
            a_d = haddr[7:0];
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ap_q <= 1'b0;
            wr_q <= 1'b0;
            a_q <= 8'h00;
        end else begin
            ap_q <= ap_d;
            wr_q <= wr_d;
            a_q <= a_d;
        end
    end
    // command writes while a move runs wait, so no move is dropped
    assign hreadyout = !(ap_q && wr_q && a_q == mau_pkg::OFF_CMD && busy);
    assign hresp = 1'b0;
    logic bus_wr;
    assign bus_wr = ap_q && wr_q && hreadyout;
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [2:0] stretch_q, stretch_d;
    logic [7:0] page_q, page_d;
    logic psel_q, psel_d;
    logic [15:0] dp0_q, dp0_d, dp1_q, dp1_d;
    logic [2:0] div_q, div_d;
    logic [7:0] rdat_q, rdat_d;
    logic [7:0] code_q, code_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] act_dp;
    assign act_dp = psel_q ? dp1_q : dp0_q;
    // ---------------------------------------------------------------
    // move sequencer
    // ---------------------------------------------------------------
    mau_pkg::mau_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic is_wr_q, is_wr_d;
    logic [15:0] maddr_q, maddr_d;
    logic [7:0] mwd_q, mwd_d;
    logic code_rd_q, code_rd_d;
    logic [15:0] caddr_q, caddr_d;
    mau_pkg::mau_cmd_t op;
    logic [7:0] cdat;
    logic [15:0] ri_addr;
    assign busy = st_q != mau_pkg::ST_IDLE;
    assign op = mau_pkg::mau_cmd_t'(hwdata[mau_pkg::CMD_OP_LSB +: 4]);
    assign cdat = hwdata[mau_pkg::CMD_DATA_LSB +: 8];
    assign ri_addr = {page_q, hwdata[7:0]};
    logic mapped;
    always_comb begin
        sel_gen_ram = maddr_q <= mau_pkg::GENERAL_DATA_RAM_HI;
        sel_engine_data_ram = maddr_q >= mau_pkg::EDRAM_LO && maddr_q <= mau_pkg::EDRAM_HI;
        sel_io_ram = maddr_q >= mau_pkg::IORAM_LO && maddr_q <= mau_pkg::IORAM_HI;
        sel_engine_program_ram = maddr_q >= mau_pkg::EPRAM_LO && maddr_q <= mau_pkg::EPRAM_HI;
        mapped = sel_gen_ram | sel_engine_data_ram | sel_io_ram | sel_engine_program_ram;
    end
    // strobe length: read stretch+1, write max(stretch,1)
    logic [3:0] wr_strobe;
    assign wr_strobe = (stretch_q <= 3'h1) ? 4'h1 : {1'b0, stretch_q};
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        is_wr_d = is_wr_q;
        maddr_d = maddr_q;
        mwd_d = mwd_q;
        code_rd_d = 1'b0;
        caddr_d = caddr_q;
        pc_d = pc_q;
        rdat_d = rdat_q;
        code_d = code_q;
        stretch_d = stretch_q;
        page_d = page_q;
        psel_d = psel_q;
        dp0_d = dp0_q;
        dp1_d = dp1_q;
        div_d = div_q;
        if (bus_wr) begin
            unique case (a_q)
                mau_pkg::OFF_STRETCH: stretch_d = hwdata[2:0];
                mau_pkg::OFF_PAGE: page_d = hwdata[7:0];
                mau_pkg::OFF_PSEL: psel_d = hwdata[0];
                mau_pkg::OFF_DPTR0: dp0_d = hwdata[15:0];
                mau_pkg::OFF_SECONDARY_DATA_POINTER: dp1_d = hwdata[15:0];
                mau_pkg::OFF_CLKDIV: div_d = hwdata[2:0];
                mau_pkg::OFF_CMD: begin
                    unique case (op)
                        mau_pkg::CMD_RD_RI, mau_pkg::CMD_WR_RI,
                        mau_pkg::CMD_RD_DP, mau_pkg::CMD_WR_DP: begin
                            is_wr_d = op == mau_pkg::CMD_WR_RI || op == mau_pkg::CMD_WR_DP;
                            maddr_d = (op == mau_pkg::CMD_RD_RI || op == mau_pkg::CMD_WR_RI)
                                ? ri_addr : act_dp;
                            mwd_d = cdat;
                            cnt_d = 4'h0;
                            // reads raise address and strobe together, so both
                            // last stretch+1; a write at stretch 0 has no lead
                            // cycle, leaving strobe plus trail as its two
                            if (is_wr_d && stretch_q != 3'h0) begin
                                st_d = mau_pkg::ST_ADDR;
                            end else begin
                                st_d = mau_pkg::ST_STROBE;
                            end
                        end
                        mau_pkg::CMD_INC_DP: begin
                            if (psel_q) begin
                                dp1_d = dp1_q + 16'h0001;
                            end else begin
                                dp0_d = dp0_q + 16'h0001;
                            end
                        end
                        mau_pkg::CMD_FETCH: begin
                            caddr_d = pc_q;
                            pc_d = pc_q + 16'h0001;
                            code_rd_d = 1'b1;
                            st_d = mau_pkg::ST_CODE;
                        end
                        mau_pkg::CMD_MOVC: begin
                            caddr_d = act_dp + {8'h00, hwdata[7:0]};
                            code_rd_d = 1'b1;
                            st_d = mau_pkg::ST_CODE;
                        end
                        mau_pkg::CMD_VECTOR: begin
                            pc_d = mau_pkg::VEC_BASE + {9'h000, hwdata[4:0], 2'b00} * 16'h0002;
                        end
                        default: begin
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
        unique case (st_q)
            mau_pkg::ST_IDLE: begin
            end
            mau_pkg::ST_ADDR: begin
                // write: lead cycles, then strobe, then one trailing cycle make
                // stretch+2; the lead lasts stretch+1 minus strobe length cycles
                if (is_wr_q) begin
                    if (cnt_q == 4'({1'b0, stretch_q}) - wr_strobe) begin
                        cnt_d = 4'h0;
                        st_d = mau_pkg::ST_STROBE;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end else begin
                    cnt_d = 4'h0;
                    st_d = mau_pkg::ST_STROBE;
                end
            end
            mau_pkg::ST_STROBE: begin
                if (is_wr_q) begin
                    if (cnt_q == wr_strobe - 4'h1) begin
                        st_d = mau_pkg::ST_ADDR;
                        cnt_d = 4'hf;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end else if (cnt_q == {1'b0, stretch_q}) begin
                    rdat_d = mapped ? mem_rdata : mau_pkg::UNMAPPED_DATA;
                    st_d = mau_pkg::ST_IDLE;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            mau_pkg::ST_CODE: begin
                code_d = code_rdata;
                st_d = mau_pkg::ST_IDLE;
            end
            default: st_d = mau_pkg::ST_IDLE;
        endcase
        // trailing write address cycle after the strobe
        if (st_q == mau_pkg::ST_ADDR && is_wr_q && cnt_q == 4'hf) begin
            st_d = mau_pkg::ST_IDLE;
            cnt_d = 4'h0;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= mau_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            is_wr_q <= 1'b0;
            maddr_q <= 16'h0000;
            mwd_q <= 8'h00;
            code_rd_q <= 1'b0;
            caddr_q <= mau_pkg::RESET_PC;
            pc_q <= mau_pkg::RESET_PC;
            rdat_q <= 8'h00;
            code_q <= 8'h00;
            stretch_q <= mau_pkg::STRETCH_RST;
            page_q <= mau_pkg::PAGE_RST;
            psel_q <= 1'b0;
            dp0_q <= mau_pkg::PRIMARY_DATA_POINTER_RST;
            dp1_q <= mau_pkg::PRIMARY_DATA_POINTER_RST;
            div_q <= mau_pkg::CLKDIV_RST;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            is_wr_q <= is_wr_d;
            maddr_q <= maddr_d;
            mwd_q <= mwd_d;
            code_rd_q <= code_rd_d;
            caddr_q <= caddr_d;
            pc_q <= pc_d;
            rdat_q <= rdat_d;
            code_q <= code_d;
            stretch_q <= stretch_d;
            page_q <= page_d;
            psel_q <= psel_d;
            dp0_q <= dp0_d;
            dp1_q <= dp1_d;
            div_q <= div_d;
        end
    end
    // ---------------------------------------------------------------
    // memory port outputs
    // ---------------------------------------------------------------
    assign mem_addr = maddr_q;
    assign mem_wdata = mwd_q;
    assign mem_addr_valid = busy && st_q != mau_pkg::ST_CODE;
    assign mem_rd = st_q == mau_pkg::ST_STROBE && !is_wr_q;
    assign mem_wr = st_q == mau_pkg::ST_STROBE && is_wr_q && mapped;
    assign code_addr = caddr_q;
    assign code_rd = code_rd_q;
    // ---------------------------------------------------------------
    // clock enable divider: one pulse every 2^div cycles
    // ---------------------------------------------------------------
    logic [7:0] dcnt_q, dcnt_d;
    logic [7:0] dlim;
    assign dlim = 8'((9'h001 << div_q) - 9'h001);
    always_comb begin
        dcnt_d = (dcnt_q >= dlim) ? 8'h00 : dcnt_q + 8'h01;
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dcnt_q <= 8'h00;
        end else begin
            dcnt_q <= dcnt_d;
        end
    end
    assign cpu_clk_en = dcnt_q >= dlim;
    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    logic [31:0] rd_d, rd_q;
    always_comb begin
        rd_d = 32'h0000_0000;
        if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                mau_pkg::OFF_STRETCH: rd_d = {29'h0, stretch_q};
                mau_pkg::OFF_PAGE: rd_d = {24'h0, page_q};
                mau_pkg::OFF_PSEL: rd_d = {31'h0, psel_q};
                mau_pkg::OFF_DPTR0: rd_d = {16'h0, dp0_q};
                mau_pkg::OFF_SECONDARY_DATA_POINTER: rd_d = {16'h0, dp1_q};
                mau_pkg::OFF_STATUS: rd_d = {15'h0, busy, pc_q};
                mau_pkg::OFF_RDATA: rd_d = {24'h0, rdat_q};
                mau_pkg::OFF_CODE: rd_d = {24'h0, code_q};
                mau_pkg::OFF_CLKDIV: rd_d = {29'h0, div_q};
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_q <= 32'h0000_0000;
        end else begin
            rd_q <= rd_d;
        end
    end
    assign hrdata = rd_q;
endmodule
`default_nettype wire

// file: verif/mau_sva.sv
// checker: move strobes, data decode and code port of the memory access unit
// assumes binding into mau_top, one clock, reset asynchronous and active low
`timescale 1ns/1ps
`default_nettype none
module mau_sva (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic hreadyout,
    input wire logic [15:0] mem_addr,
    input wire logic mem_addr_valid,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic sel_gen_ram,
    input wire logic sel_engine_data_ram,
    input wire logic sel_io_ram,
    input wire logic sel_engine_program_ram,
    input wire logic code_rd
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ----------
    // sequences and properties
    // ----------
    sequence s_trail; mem_addr_valid ##1 !mem_addr_valid; endsequence
    sequence s_rd_full; mem_rd [*8]; endsequence
    property p_one_dir; !(mem_rd && mem_wr); endproperty
    a_one_dir: assert property (p_one_dir) else $error("read and write strobes overlap");
    property p_rd_lead; $rose(mem_rd) |-> $rose(mem_addr_valid); endproperty
    a_rd_lead: assert property (p_rd_lead) else $error("read address not with strobe");
    property p_rd_max; s_rd_full |=> !mem_rd; endproperty
    a_rd_max: assert property (p_rd_max) else $error("read strobe over 8 cycles");
    property p_rd_end; $fell(mem_rd) |-> !mem_addr_valid; endproperty
    a_rd_end: assert property (p_rd_end) else $error("read address outlives strobe");
    property p_wr_max; mem_wr [*7] |=> !mem_wr; endproperty
    a_wr_max: assert property (p_wr_max) else $error("write strobe over 7 cycles");
    property p_wr_trail; $fell(mem_wr) |-> s_trail; endproperty
    a_wr_trail: assert property (p_wr_trail) else $error("write trail cycle wrong");
    property p_wr_hit;
        mem_wr |-> sel_gen_ram | sel_engine_data_ram | sel_io_ram | sel_engine_program_ram;
    endproperty
    a_wr_hit: assert property (p_wr_hit) else $error("write strobe to empty space");
    property p_general_data_ram; mem_addr_valid |-> sel_gen_ram == (mem_addr <= 16'h07ff); endproperty
    a_general_data_ram: assert property (p_general_data_ram) else $error("general ram decode wrong");
    property p_epram;
        mem_addr_valid |-> sel_engine_program_ram == (mem_addr[15:12] == 4'h3);
    endproperty
    a_epram: assert property (p_epram) else $error("program ram decode wrong");
    property p_hold; mem_addr_valid && $past(mem_addr_valid) |-> $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("move address changed");
    property p_code; code_rd |=> !code_rd; endproperty
    a_code: assert property (p_code) else $error("code read longer than one cycle");
    property p_stall; $fell(hreadyout) |-> ##[1:60] hreadyout; endproperty
    a_stall: assert property (p_stall) else $error("bus stalled too long");
endmodule
bind mau_top mau_sva u_mau_sva (.mclk, .arst_n, .hreadyout, .mem_addr, .mem_addr_valid,
    .mem_rd, .mem_wr, .sel_gen_ram, .sel_engine_data_ram, .sel_io_ram,
    .sel_engine_program_ram, .code_rd);
`default_nettype wire

// file: verif/mau_mem.sv
// partner model: data memories and code store behind the move and code ports
// assumes one clock; hit is the or of the four decode selects
`timescale 1ns/1ps
`default_nettype none
module mau_mem (
    input wire logic mclk,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic hit,
    input wire logic [15:0] code_addr,
    input wire logic code_rd,
    output logic [7:0] code_rdata
);
    logic [7:0] ram [0:65535];
    logic [7:0] lm = 8'h00;
    logic [7:0] lc = 8'h00;
    // idle lines toggle so a stale byte is never taken for data
    assign mem_rdata = mem_rd ? ram[mem_addr] : ~lm;
    assign code_rdata = code_rd ? (code_addr[7:0] ^ code_addr[15:8] ^ 8'h5a) : ~lc;
    always @(posedge mclk) begin
        lm <= mem_rdata;
        lc <= code_rdata;
        if (mem_wr && hit) ram[mem_addr] <= mem_wdata;
    end
endmodule
`default_nettype wire

// file: verif/mau_top_tb.sv
// testbench for the memory access unit: register bus, moves, pointers, code port
// assumes mau_top, the mau_mem partner and the bound checker
`timescale 1ns/1ps
`default_nettype none
module mau_top_tb;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rd_dp = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, mem_addr_valid, mem_rd, mem_wr, code_rd, cpu_clk_en, hit, rh;
    logic sel_gen_ram, sel_engine_data_ram, sel_io_ram, sel_engine_program_ram;
    logic [15:0] mem_addr, code_addr, ra, wa;
    logic [15:0] rc = '0;
    logic [15:0] wc = '0;
    logic [15:0] vc = '0;
    logic [7:0] mem_wdata, mem_rdata, code_rdata;
    logic [15:0] bs [4] = '{16'h0000, 16'h1000, 16'h2000, 16'h3000};
    logic [15:0] bm [4] = '{16'h07ff, 16'h03ff, 16'h00ff, 16'h0fff};
    logic [31:0] eq[$], mq[$], rq[$], wq[$], vq[$];
    string nq[$];
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int ce_n = 0;
    assign hit = sel_gen_ram | sel_engine_data_ram | sel_io_ram | sel_engine_program_ram;
    always #2.5 mclk = ~mclk;
    mau_top u_mau_top (.mclk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_addr, .mem_wdata, .mem_rdata,
        .mem_addr_valid, .mem_rd, .mem_wr, .sel_gen_ram, .sel_engine_data_ram, .sel_io_ram,
        .sel_engine_program_ram, .code_addr, .code_rd, .code_rdata, .cpu_clk_en);
    mau_mem u_mau_mem (.mclk, .mem_addr, .mem_wdata, .mem_rdata, .mem_rd, .mem_wr, .hit,
        .code_addr, .code_rd, .code_rdata);
    // ----------
    // bus tasks and monitors
    // ----------
    function automatic logic [7:0] cb(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5a;
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
        output logic [31:0] r);
        haddr <= {24'h0, a};
        hwrite <= w;
        hsel <= 1'b1;
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= c;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
        r = hrdata;
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e, logic [31:0] m);
        logic [31:0] r;
        eq.push_back(e & m);
        mq.push_back(m);
        nq.push_back(n);
        bus(1'b0, a, '0, 1'b1, r);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, 1'b0, r);
    endtask
    // busy is polled because a later register read is not stalled by a move
    task automatic cmd(input mau_pkg::mau_cmd_t op, input logic [7:0] b, input logic [7:0] lo);
        logic [31:0] r;
        wr(mau_pkg::OFF_CMD, {4'h0, op, b, 8'h00, lo});
        for (int k = 0; k < 60; k++) begin
            bus(1'b0, mau_pkg::OFF_STATUS, '0, 1'b0, r);
            if (r[16] === 1'b0) break;
        end
    endtask
    always @(posedge mclk) begin
        if (rd_dp && hreadyout === 1'b1) begin
            chk(nq.pop_front(), hrdata & mq.pop_front(), eq.pop_front());
        end
        if (mem_rd === 1'b1) begin
            rc <= rc + 16'h1;
            ra <= mem_addr;
            rh <= hit;
        end else if (rc != 0) begin
            rc <= '0;
            if (rh) chk("rd_strobe", {ra, rc}, rq.pop_front());
        end
        if (mem_wr === 1'b1) begin
            wc <= wc + 16'h1;
            wa <= mem_addr;
        end else if (wc != 0) begin
            wc <= '0;
            chk("wr_strobe", {wa, wc}, wq.pop_front());
        end
        if (mem_addr_valid === 1'b1) begin
            vc <= vc + 16'h1;
        end else if (vc != 0) begin
            vc <= '0;
            chk("addr_width", {16'h0, vc}, vq.pop_front());
        end
        ce_n <= ce_n + int'(cpu_clk_en);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            test_done;
        end
    end
    // ----------
    // tests
    // ----------
    initial begin
        logic [31:0] v;
        logic [15:0] a;
        logic [15:0] p;
        logic [7:0] b;
        int n0;
        v = $urandom(32'h89cc0991);
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rd("stretch", mau_pkg::OFF_STRETCH, 32'h1, 32'h7);
        rd("status", mau_pkg::OFF_STATUS, '0, 32'h1ffff);
        rd("psel", mau_pkg::OFF_PSEL, '0, 32'h1);
        rd("ptr0", mau_pkg::OFF_DPTR0, '0, 32'hffff);
        rd("ptr1", mau_pkg::OFF_SECONDARY_DATA_POINTER, '0, 32'hffff);
        rd("hole", 8'h3c, '0, '1);
        $display("test reset done");
        for (int s = 0; s < 8; s++) begin
            v = $urandom;
            a = bs[s % 4] | (v[15:0] & bm[s % 4]);
            b = v[23:16];
            wr(mau_pkg::OFF_STRETCH, {v[31:3], 3'(s)});
            rd("stretch", mau_pkg::OFF_STRETCH, 32'(s), 32'h7);
            wr(mau_pkg::OFF_PAGE, {24'h0, a[15:8]});
            wr(mau_pkg::OFF_DPTR0, {16'h0, a});
            wq.push_back({a, s < 2 ? 16'h1 : 16'(s)});
            vq.push_back(32'(s + 2));
            cmd(s[0] ? mau_pkg::CMD_WR_RI : mau_pkg::CMD_WR_DP, b, a[7:0]);
            rq.push_back({a, 16'(s + 1)});
            vq.push_back(32'(s + 1));
            cmd(s[0] ? mau_pkg::CMD_RD_DP : mau_pkg::CMD_RD_RI, 8'h0, a[7:0]);
            rd("move_data", mau_pkg::OFF_RDATA, {24'h0, b}, 32'hff);
        end
        $display("test stretch done");
        p = v[15:0] ^ 16'h5a5a;
        wr(mau_pkg::OFF_DPTR0, {16'h0, p});
        wr(mau_pkg::OFF_SECONDARY_DATA_POINTER, {16'h0, a - 16'h1});
        wr(mau_pkg::OFF_PSEL, 32'h1);
        cmd(mau_pkg::CMD_INC_DP, 8'h0, 8'h0);
        rd("ptr0", mau_pkg::OFF_DPTR0, {16'h0, p}, 32'hffff);
        rd("ptr1", mau_pkg::OFF_SECONDARY_DATA_POINTER, {16'h0, a}, 32'hffff);
        rq.push_back({a, 16'h8});
        vq.push_back(32'h8);
        cmd(mau_pkg::CMD_RD_DP, 8'h0, 8'h0);
        rd("move_data", mau_pkg::OFF_RDATA, {24'h0, b}, 32'hff);
        wr(mau_pkg::OFF_PSEL, '0);
        a = 16'h0800 | (p & 16'h07ff);
        wr(mau_pkg::OFF_DPTR0, {16'h0, a});
        vq.push_back(32'h9);
        cmd(mau_pkg::CMD_WR_DP, b, 8'h0);
        vq.push_back(32'h8);
        cmd(mau_pkg::CMD_RD_DP, 8'h0, 8'h0);
        rd("void_data", mau_pkg::OFF_RDATA, 32'hff, 32'hff);
        $display("test pointer done");
        cmd(mau_pkg::CMD_FETCH, 8'h0, 8'h0);
        rd("code", mau_pkg::OFF_CODE, {24'h0, cb(16'h0)}, 32'hff);
        for (int s = 0; s < 8; s++) begin
            p = 16'h0003 + 16'(s * 8);
            cmd(mau_pkg::CMD_VECTOR, 8'h0, 8'(s));
            rd("vector", mau_pkg::OFF_STATUS, {16'h0, p}, 32'h1ffff);
            cmd(mau_pkg::CMD_FETCH, 8'h0, 8'h0);
            rd("code", mau_pkg::OFF_CODE, {24'h0, cb(p)}, 32'hff);
        end
        p = v[31:16];
        wr(mau_pkg::OFF_DPTR0, {16'h0, p});
        cmd(mau_pkg::CMD_MOVC, 8'h0, b);
        rd("code", mau_pkg::OFF_CODE, {24'h0, cb(p + 16'(b))}, 32'hff);
        $display("test code done");
        for (int s = 0; s < 4; s++) begin
            wr(mau_pkg::OFF_CLKDIV, 32'(s));
            repeat (8) @(posedge mclk);
            n0 = ce_n;
            repeat (64) @(posedge mclk);
            chk("clk_en", 32'(ce_n - n0), 32'(64 >> s));
        end
        $display("test divider done");
        test_done;
    end
endmodule
`default_nettype wire
